/* File: rtl/fifo_flag_pkg.sv */
`default_nettype none
package fifo_flag_pkg;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 12;
	localparam int CNT_W = 13;
	// Storage depth with an 18-bit port, and with both ports 9 bits wide.
	localparam logic [CNT_W-1:0] DEPTH_WIDE = 13'h0800;
	localparam logic [CNT_W-1:0] DEPTH_NARROW = 13'h1000;
	// Fall-through timing counts the output register as one more word.
	localparam logic [CNT_W-1:0] FT_EXTRA = 13'h0001;
	localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
	localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic FLAG_N_RST = 1'b1;
	localparam logic AE_N_RST = 1'b0;

	typedef struct packed {
		logic sync_flags;
		logic fall_through;
		logic narrow;
		logic async_read;
	} mode_type;

	typedef struct packed {
		logic select_n;
		logic enable_n;
		logic output_enable_n;
	} read_ctrl_type;

	localparam mode_type MODE_RST = 4'h0;
endpackage : fifo_flag_pkg
`default_nettype wire

/* File: rtl/fifo_status_flags.sv */
// Overview of operation
// - Flag-timing select high during master reset selects synchronous almost flags.
// - Flag-timing select low during master reset selects asynchronous almost flags.
// - Synchronous almost-full changes only on write-side clock edges.
// - Synchronous almost-full releases one write cycle after space is freed.
// - Synchronous almost-empty releases one read cycle after a write.
// - Asynchronous almost-full asserts on a write, releases on a read.
// - Asynchronous almost-empty asserts on a read, releases on a write.
// - Standard timing full depth equals storage depth: 2,048 or 4,096.
// - Fall-through full depth is one more: 2,049 or 4,097.
// - Standard timing: echoed read enable is select AND enable, registered, while data is held.
// - Echoed read enable is forced high while the FIFO is empty.
// - Output bus driven only in the cycle after select and output enable are both low (registered).
// - Fall-through: first word loads output register unasked, output-ready goes low.
// - Fall-through: echoed read enable low when a new word enters the register.
// - Fall-through: read past last word raises output-ready and echoed enable.
// - Asynchronous read port timing only exists in standard timing.
`default_nettype none
module fifo_status_flags
(
	// Clock and reset.
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	// Master reset and the selections it latches.
	input  wire logic                                master_reset_n,
	input  wire logic                                flag_timing_select,
	input  wire logic                                fall_through_timing,
	input  wire logic                                narrow_ports,
	input  wire logic                                async_read_select,
	input  wire logic [fifo_flag_pkg::CNT_W-1:0]     almost_empty_offset,
	input  wire logic [fifo_flag_pkg::CNT_W-1:0]     almost_full_offset,
	// Write port.
	input  wire logic                                write_en_n,
	input  wire logic [fifo_flag_pkg::DATA_W-1:0]    data_in,
	// Read port.
	input  wire fifo_flag_pkg::read_ctrl_type        read_ctrl,
	output logic      [fifo_flag_pkg::DATA_W-1:0]    data_out_bus,
	output logic                                     data_out_oe,
	output logic                                     echoed_read_enable_n,
	// Status flags.
	output logic                                     empty_flag_n,
	output logic                                     output_ready_n,
	output logic                                     full_flag_n,
	output logic                                     half_full_flag_n,
	output logic                                     almost_full_flag_n,
	output logic                                     almost_empty_flag_n,
	output logic                                     async_read_active
);
	import fifo_flag_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [CNT_W-1:0] depth_of(input mode_type m);
		logic [CNT_W-1:0] base;
		base = m.narrow ? DEPTH_NARROW : DEPTH_WIDE;
		depth_of = m.fall_through ? CNT_W'(base + FT_EXTRA) : base;
	endfunction : depth_of

	function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] p, input logic narrow);
		logic [ADDR_W-1:0] inc;
		inc = ADDR_W'(p + 12'h001);
		next_ptr = narrow ? inc : {1'b0, inc[ADDR_W-2:0]};
	endfunction : next_ptr

	function automatic logic af_n(input logic [CNT_W-1:0] total, input logic [CNT_W-1:0] depth,
			input logic [CNT_W-1:0] off);
		af_n = !(total >= CNT_W'(depth - off));
	endfunction : af_n

	function automatic logic ae_n(input logic [CNT_W-1:0] total, input logic [CNT_W-1:0] off);
		ae_n = !(total <= off);
	endfunction : ae_n

	////////////////////////////////////////////////////////////////////////////
	mode_type           mode_ff;
	logic [CNT_W-1:0]   ae_off_ff;
	logic [CNT_W-1:0]   af_off_ff;
	logic [DATA_W-1:0]  mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0]  wr_ptr_ff;
	logic [ADDR_W-1:0]  rd_ptr_ff;
	logic [CNT_W-1:0]   count_ff;
	logic               out_valid_ff;
	logic [DATA_W-1:0]  out_reg_ff;
	logic               oe_ff;
	logic               echo_ff;
	logic               empty_ff;
	logic               ready_ff;
	logic               full_ff;
	logic               half_ff;
	logic               af_ff;
	logic               ae_ff;
	logic               async_rd_ff;

	wire logic [CNT_W-1:0] base_depth = mode_ff.narrow ? DEPTH_NARROW : DEPTH_WIDE;
	wire logic [CNT_W-1:0] depth = depth_of(mode_ff);
	wire logic rd_req = !read_ctrl.select_n && !read_ctrl.enable_n;
	wire logic ft_mode = mode_ff.fall_through;
	wire logic stored = count_ff != CNT_RST;
	wire logic [CNT_W-1:0] total = CNT_W'(count_ff + {12'h000, ft_mode & out_valid_ff});
	wire logic wr_ok = !write_en_n && (count_ff < base_depth);
	wire logic std_rd = !ft_mode && rd_req && stored;
	wire logic ft_load = ft_mode && stored && (!out_valid_ff || rd_req);
	wire logic ft_drain = ft_mode && rd_req && out_valid_ff && !stored;
	wire logic pop = std_rd || ft_load;
	wire logic [CNT_W-1:0] nxt_count = CNT_W'(count_ff + {12'h000, wr_ok} - {12'h000, pop});
	wire logic nxt_out_valid = ft_load ? 1'b1 : (ft_drain ? 1'b0 : out_valid_ff);
	wire logic [CNT_W-1:0] nxt_total = CNT_W'(nxt_count + {12'h000, ft_mode & nxt_out_valid});
	// Synchronous flags look at the settled count, asynchronous ones follow the event at once.
	wire logic [CNT_W-1:0] flag_total = mode_ff.sync_flags ? total : nxt_total;
	wire logic nxt_af = af_n(flag_total, depth, af_off_ff);
	wire logic nxt_ae = ae_n(flag_total, ae_off_ff);
	wire logic nxt_half = !(nxt_total > {1'b0, depth[CNT_W-1:1]});
	wire logic nxt_echo = ft_mode ? !ft_load : (!stored || read_ctrl.select_n || read_ctrl.enable_n);
	wire logic nxt_oe = !read_ctrl.select_n && !read_ctrl.output_enable_n;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_ff <= MODE_RST;
			ae_off_ff <= CNT_RST;
			af_off_ff <= CNT_RST;
			async_rd_ff <= 1'b0;
		end
		else if (!master_reset_n)
		begin
			mode_ff <= '{flag_timing_select, fall_through_timing, narrow_ports, async_read_select};
			ae_off_ff <= almost_empty_offset;
			af_off_ff <= almost_full_offset;
			async_rd_ff <= async_read_select && !fall_through_timing;
		end
	end

	always_ff @(posedge clk)
	begin
		if (wr_ok)
			mem[wr_ptr_ff] <= data_in;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_ff <= PTR_RST;
			rd_ptr_ff <= PTR_RST;
			count_ff <= CNT_RST;
			out_valid_ff <= 1'b0;
			out_reg_ff <= DATA_RST;
		end
		else if (!master_reset_n)
		begin
			wr_ptr_ff <= PTR_RST;
			rd_ptr_ff <= PTR_RST;
			count_ff <= CNT_RST;
			out_valid_ff <= 1'b0;
			out_reg_ff <= DATA_RST;
		end
		else
		begin
			if (wr_ok)
				wr_ptr_ff <= next_ptr(wr_ptr_ff, mode_ff.narrow);
			if (pop)
			begin
				rd_ptr_ff <= next_ptr(rd_ptr_ff, mode_ff.narrow);
				out_reg_ff <= mem[rd_ptr_ff];
			end
			count_ff <= nxt_count;
			out_valid_ff <= nxt_out_valid;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{oe_ff, echo_ff, empty_ff, ready_ff} <= {1'b0, FLAG_N_RST, AE_N_RST, FLAG_N_RST};
			{full_ff, half_ff, af_ff, ae_ff} <= {FLAG_N_RST, FLAG_N_RST, FLAG_N_RST, AE_N_RST};
		end
		else if (!master_reset_n)
		begin
			{oe_ff, echo_ff, empty_ff, ready_ff} <= {1'b0, FLAG_N_RST, AE_N_RST, FLAG_N_RST};
			{full_ff, half_ff, af_ff, ae_ff} <= {FLAG_N_RST, FLAG_N_RST, FLAG_N_RST, AE_N_RST};
		end
		else
		begin
			oe_ff <= nxt_oe;
			echo_ff <= nxt_echo;
			empty_ff <= nxt_count != CNT_RST;
			ready_ff <= !nxt_out_valid;
			full_ff <= nxt_total < depth;
			half_ff <= nxt_half;
			af_ff <= nxt_af;
			ae_ff <= nxt_ae;
		end
	end

	assign data_out_bus = out_reg_ff;
	assign data_out_oe = oe_ff;
	assign echoed_read_enable_n = echo_ff;
	assign empty_flag_n = empty_ff;
	assign output_ready_n = ready_ff;
	assign full_flag_n = full_ff;
	assign half_full_flag_n = half_ff;
	assign almost_full_flag_n = af_ff;
	assign almost_empty_flag_n = ae_ff;
	assign async_read_active = async_rd_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !master_reset_n);

	AST_SYNC_SELECT: assert property ($rose(master_reset_n) |->
		mode_ff.sync_flags == $past(flag_timing_select))
		else $error("Flag timing mode not latched at master reset.");

	AST_ASYNC_SELECT: assert property ($rose(master_reset_n) && !$past(flag_timing_select) |->
		!mode_ff.sync_flags)
		else $error("Asynchronous flag timing not selected.");

	AST_SYNC_AF_LAG: assert property (mode_ff.sync_flags && $stable(mode_ff) ##1 mode_ff.sync_flags |->
		almost_full_flag_n == af_n($past(total), depth, af_off_ff))
		else $error("Synchronous almost-full did not follow the settled count.");

	AST_SYNC_AF_RELEASE: assert property (mode_ff.sync_flags && total < CNT_W'(depth - af_off_ff) |=>
		almost_full_flag_n)
		else $error("Synchronous almost-full did not release after space was freed.");

	AST_SYNC_AE_RELEASE: assert property (mode_ff.sync_flags && total > ae_off_ff && stored |->
		##[1:2] almost_empty_flag_n)
		else $error("Synchronous almost-empty did not release.");

	AST_SYNC_AE_HOLD: assert property (mode_ff.sync_flags && total <= ae_off_ff |=>
		!almost_empty_flag_n)
		else $error("Synchronous almost-empty not active at or below its offset.");

	AST_ASYNC_AF: assert property (!mode_ff.sync_flags && nxt_total >= CNT_W'(depth - af_off_ff) |=>
		!almost_full_flag_n)
		else $error("Asynchronous almost-full not asserted on the write.");

	AST_ASYNC_AF_RELEASE: assert property (!mode_ff.sync_flags &&
		nxt_total < CNT_W'(depth - af_off_ff) |=> almost_full_flag_n)
		else $error("Asynchronous almost-full not released on the read.");

	AST_ASYNC_AE: assert property (!mode_ff.sync_flags && nxt_total > ae_off_ff |=>
		almost_empty_flag_n)
		else $error("Asynchronous almost-empty not released on the write.");

	AST_ASYNC_AE_ASSERT: assert property (!mode_ff.sync_flags && nxt_total <= ae_off_ff |=>
		!almost_empty_flag_n)
		else $error("Asynchronous almost-empty not asserted on the read.");

	AST_ECHO_AND: assert property (!ft_mode && stored |=>
		echoed_read_enable_n == $past(read_ctrl.select_n || read_ctrl.enable_n))
		else $error("Echoed read enable does not follow select and enable.");

	AST_ECHO_BLOCKED: assert property (!ft_mode && stored && rd_req |=> !echoed_read_enable_n)
		else $error("Echoed read enable high on an enabled read with data held.");

	AST_ECHO_EMPTY: assert property (!ft_mode && !stored |=> echoed_read_enable_n)
		else $error("Echoed read enable low while empty.");

	AST_BUS_GATE: assert property (data_out_oe |->
		$past(!read_ctrl.select_n && !read_ctrl.output_enable_n))
		else $error("Output bus driven without select and output enable.");

	AST_BUS_OPEN: assert property (!read_ctrl.select_n && !read_ctrl.output_enable_n |=> data_out_oe)
		else $error("Output bus not driven with select and output enable low.");

	AST_FALL_THROUGH: assert property (ft_mode && !out_valid_ff && stored |=>
		!output_ready_n ##0 !echoed_read_enable_n)
		else $error("First word did not fall through.");

	AST_NEW_WORD_ECHO: assert property (ft_load |=> !echoed_read_enable_n)
		else $error("Echoed read enable high on a new word.");

	AST_DRAIN: assert property (ft_drain |=> output_ready_n && echoed_read_enable_n)
		else $error("Read past the last word not flagged.");

	AST_NO_ASYNC_FT: assert property (async_read_active |-> !mode_ff.fall_through)
		else $error("Asynchronous read offered in fall-through timing.");

	AST_ASYNC_READ_STD: assert property ($rose(master_reset_n) && $past(async_read_select) &&
		!$past(fall_through_timing) |-> async_read_active)
		else $error("Asynchronous read not offered in standard timing.");

	AST_STD_DEPTH: assert property (!full_flag_n && !ft_mode |->
		total == (mode_ff.narrow ? DEPTH_NARROW : DEPTH_WIDE))
		else $error("Standard timing full flag at the wrong depth.");

	AST_FULL_DEPTH: assert property (!full_flag_n |->
		total == (ft_mode ? CNT_W'(base_depth + FT_EXTRA) : base_depth))
		else $error("Full flag at the wrong depth.");

	AST_HALF: assert property (nxt_total > {1'b0, depth[CNT_W-1:1]} |=> !half_full_flag_n)
		else $error("Half-full flag missed.");

	AST_HALF_RELEASE: assert property (nxt_total <= {1'b0, depth[CNT_W-1:1]} |=> half_full_flag_n)
		else $error("Half-full flag not released.");
endmodule : fifo_status_flags
`default_nettype wire

/* File: testbench/fifo_far_side_model.sv */
`default_nettype none
module fifo_far_side_model
(
	// Clock.
	input  wire logic                                clk,
	// Controls towards the block.
	output logic                                     write_en_n,
	output logic      [fifo_flag_pkg::DATA_W-1:0]    data_in,
	output fifo_flag_pkg::read_ctrl_type             read_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;
	import fifo_flag_pkg::*;

	initial
	begin
		write_en_n = 1'b1;
		data_in = '0;
		read_ctrl = 3'b111;
	end

	// One cycle with an optional write or read, two when a read must first lower select; idle controls wander at random.
	task automatic cycle(input logic wr, input logic rd, input logic [DATA_W-1:0] d);
		if (rd && read_ctrl.select_n)
		begin
			@(posedge clk);
			// The lead-in cycle carries no write, so the tracked count stays true.
			write_en_n <= 1'b1;
			read_ctrl.select_n <= 1'b0;
		end
		@(posedge clk);
		write_en_n <= ~wr;
		data_in <= d;
		read_ctrl.enable_n <= ~rd;
		read_ctrl.output_enable_n <= 1'($urandom);
		if (!rd)
			read_ctrl.select_n <= 1'($urandom);
	endtask : cycle
endmodule : fifo_far_side_model
`default_nettype wire

/* File: testbench/fifo_status_flags_and_read_echo_tb_top.sv */
`default_nettype none
module fifo_status_flags_and_read_echo_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fifo_flag_pkg::*;

	logic                clk = 1'b0, rst_n = 1'b0, master_reset_n = 1'b0, mr_prev = 1'b0;
	logic                flag_timing_select = 1'b0, fall_through_timing = 1'b0;
	logic                narrow_ports = 1'b0, async_read_select = 1'b0;
	logic [CNT_W-1:0]    almost_empty_offset = '0, almost_full_offset = '0;
	logic [DATA_W-1:0]   data_in, data_out_bus;
	logic                write_en_n, data_out_oe, echoed_read_enable_n, empty_flag_n, output_ready_n;
	logic                full_flag_n, half_full_flag_n, almost_full_flag_n, almost_empty_flag_n, async_read_active;
	read_ctrl_type       read_ctrl, prev_ctrl;
	logic [DATA_W-1:0]   exp_w[$];
	logic [6:0]          exp_f[$];
	int                  n_mismatch = 0, n_compared = 0, cnt, depth, ae_off, af_off;
	int                  tgt[11];
	event                probe_ev;

	always #4 clk = ~clk;

	fifo_status_flags i_fifo_status_flags (.clk, .rst_n, .master_reset_n, .flag_timing_select,
		.fall_through_timing, .narrow_ports, .async_read_select, .almost_empty_offset, .almost_full_offset,
		.write_en_n, .data_in, .read_ctrl, .data_out_bus, .data_out_oe, .echoed_read_enable_n, .empty_flag_n,
		.output_ready_n, .full_flag_n, .half_full_flag_n, .almost_full_flag_n, .almost_empty_flag_n,
		.async_read_active);
	fifo_far_side_model i_fifo_far_side_model (.clk, .write_en_n, .data_in, .read_ctrl);

	////////////////////////////////////////////////////////////////////////////////
	task automatic bad(input string m);
		n_mismatch++;
		$display("BAD %0t %s", $time, m);
	endtask : bad

	task automatic report_and_stop();
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic do_op(input logic wr, input logic rd);
		logic [DATA_W-1:0] d;
		d = DATA_W'($urandom);
		if (wr && cnt < depth)
		begin
			cnt++;
			exp_w.push_back(d);
		end
		if (rd && cnt > 0)
			cnt--;
		i_fifo_far_side_model.cycle(wr, rd, d);
	endtask : do_op

	task automatic check_flags();
		repeat (4) do_op(1'b0, 1'b0);
		@(negedge clk);
		exp_f.push_back({cnt != 0, cnt == 0, cnt != depth, !(cnt > depth / 2), !(cnt >= depth - af_off),
			!(cnt <= ae_off), async_read_select && !fall_through_timing});
		-> probe_ev;
	endtask : check_flags

	////////////////////////////////////////////////////////////////////////////////
	always @(probe_ev)
	begin
		logic [6:0] got_f;
		got_f = {fall_through_timing ? exp_f[0][6] : empty_flag_n,
			fall_through_timing ? output_ready_n : exp_f[0][5], full_flag_n, half_full_flag_n,
			almost_full_flag_n, almost_empty_flag_n, async_read_active};
		n_compared++;
		if (got_f !== exp_f[0])
			bad("status flags");
		void'(exp_f.pop_front());
	end

	always @(negedge clk)
	begin
		if (mr_prev && master_reset_n)
		begin
			n_compared++;
			if (data_out_oe !== ~(prev_ctrl.select_n | prev_ctrl.output_enable_n))
				bad("output enable");
			if (echoed_read_enable_n === 1'b0)
			begin
				n_compared++;
				if (exp_w.size() == 0)
					bad("echo without a word");
				else if (data_out_bus !== exp_w.pop_front())
					bad("read data");
			end
		end
		mr_prev = master_reset_n;
		prev_ctrl = read_ctrl;
	end

	initial
	begin
		#400000;
		bad("timeout");
		report_and_stop();
	end

	initial
	begin
		void'($urandom(32'h6497));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clk);
			master_reset_n <= 1'b0;
			flag_timing_select <= (c == 0 || c == 3);
			fall_through_timing <= c[1];
			narrow_ports <= c[0];
			async_read_select <= 1'($urandom);
			almost_empty_offset <= CNT_W'(1 + $urandom % 16);
			almost_full_offset <= CNT_W'(1 + $urandom % 16);
			repeat (2) @(posedge clk);
			exp_w.delete();
			cnt = 0;
			ae_off = int'(almost_empty_offset);
			af_off = int'(almost_full_offset);
			depth = (narrow_ports ? 4096 : 2048) + (fall_through_timing ? 1 : 0);
			master_reset_n <= 1'b1;
			tgt = '{ae_off, ae_off + 1, depth / 2, depth / 2 + 1, depth - af_off - 1, depth - af_off, depth,
				depth - af_off - 1, ae_off + 1, ae_off, 0};
			foreach (tgt[i])
			begin
				while (cnt < tgt[i]) do_op(1'b1, 1'b0);
				while (cnt > tgt[i]) do_op(1'b0, 1'b1);
				if (i == 0)
				begin
					do_op(1'b1, 1'b0);
					do_op(1'b0, 1'b0);
					@(negedge clk);
					n_compared++;
					if (almost_empty_flag_n !== !flag_timing_select)
						bad("almost empty timing");
				end
				if (tgt[i] == depth)
					do_op(1'b1, 1'b0);
				if (tgt[i] == 0)
					do_op(1'b0, 1'b1);
				check_flags();
			end
		end
		report_and_stop();
	end
endmodule : fifo_status_flags_and_read_echo_tb_top
`default_nettype wire
